/* core/dmx_pkg.sv */
package dmx_pkg;

	// register map, byte addresses on the bus
	localparam int        DMX_AXI_AW      = 8;
	localparam logic [7:0] DMX_OFF_CTRL   = 8'h00;
	localparam logic [7:0] DMX_OFF_INSTR  = 8'h04;
	localparam logic [7:0] DMX_OFF_STATUS = 8'h08;
	localparam logic [7:0] DMX_OFF_ACC    = 8'h0C;
	localparam logic [7:0] DMX_OFF_BANK   = 8'h10;
	localparam logic [7:0] DMX_OFF_PTR0   = 8'h14;
	localparam logic [7:0] DMX_OFF_PTR1   = 8'h18;
	localparam logic [7:0] DMX_OFF_PTR2   = 8'h1C;

	// status field positions
	localparam int DMX_ST_BUSY    = 0;
	localparam int DMX_ST_PEND    = 1;
	localparam int DMX_ST_NEG     = 2;
	localparam int DMX_ST_ZERO    = 3;
	localparam int DMX_ST_ILLEGAL = 4;
	localparam int DMX_ST_BLOCKED = 5;

	// reset values
	localparam logic [7:0]  DMX_RST_BYTE = 8'h00;
	localparam logic [11:0] DMX_RST_PTR  = 12'h000;

	// opcode fields
	localparam logic [5:0] DMX_OPC_FMOVE  = 6'h14;
	localparam logic [3:0] DMX_OPC_MM1    = 4'hC;
	localparam logic [3:0] DMX_OPC_SECOND = 4'hF;
	localparam logic [7:0] DMX_OPC_BANK   = 8'h01;
	localparam logic [7:0] DMX_OPC_ACCLIT = 8'h0E;
	localparam logic [9:0] DMX_OPC_PTR1   = 10'h3B8;
	localparam logic [1:0] DMX_PTR_MAX    = 2'h2;

	// data space landmarks
	localparam logic [11:0] DMX_ACC_ADDR  = 12'hFE0;
	localparam logic [11:0] DMX_PROT_BASE = 12'hFF0;
	localparam logic [7:0]  DMX_ILO_MAX   = 8'h5F;
	localparam logic [3:0]  DMX_ACC_LOBANK = 4'h0;
	localparam logic [3:0]  DMX_ACC_HIBANK = 4'hF;

	// bus answers
	localparam logic [1:0] DMX_RESP_OKAY   = 2'h0;
	localparam logic [1:0] DMX_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		DMX_NONE,
		DMX_PTR1,
		DMX_FMOVE,
		DMX_MM1,
		DMX_SECOND,
		DMX_BANK,
		DMX_ACCLIT,
		DMX_ILLEGAL
	} dmx_op_e;

endpackage : dmx_pkg

/* core/dmx_dec_if.sv */
`timescale 1ns/1ns
// decoded fields of one instruction word
interface dmx_dec_if;
	logic [15:0]      word;
	dmx_pkg::dmx_op_e op;
	logic [7:0]       f;
	logic             d;
	logic             a;
	logic [1:0]       psel;
	logic [11:0]      lit12;
	modport src (output word, input op, f, d, a, psel, lit12);
	modport dec (input word, output op, f, d, a, psel, lit12);
endinterface : dmx_dec_if

/* core/dmx_decode.sv */
`timescale 1ns/1ns
module dmx_decode (
	// decoded word
	dmx_dec_if.dec dif
);
	import dmx_pkg::*;

	// field extraction
	assign dif.f     = dif.word[7:0];
	assign dif.d     = dif.word[9];
	assign dif.a     = dif.word[8];
	assign dif.psel  = dif.word[5:4];
	assign dif.lit12 = dif.word[11:0];

	// opcode classification
	always_comb
	begin
		dif.op = DMX_ILLEGAL;
		if (dif.word[15:10] == DMX_OPC_FMOVE)
			dif.op = DMX_FMOVE;
		else if (dif.word[15:12] == DMX_OPC_MM1)
			dif.op = DMX_MM1;
		else if (dif.word[15:12] == DMX_OPC_SECOND)
			dif.op = DMX_SECOND;
		else if (dif.word[15:8] == DMX_OPC_BANK)
			dif.op = DMX_BANK;
		else if (dif.word[15:8] == DMX_OPC_ACCLIT)
			dif.op = DMX_ACCLIT;
		else if (dif.word[15:6] == DMX_OPC_PTR1 && dif.word[5:4] <= DMX_PTR_MAX)
			dif.op = DMX_PTR1;
	end

endmodule : dmx_decode

/* core/dmx_addr.sv */
`timescale 1ns/1ns
module dmx_addr (
	// operand fields
	input  wire logic [7:0]  f,
	input  wire logic        a,
	// address context
	input  wire logic [7:0]  bank,
	input  wire logic [11:0] ilo_base,
	input  wire logic        ext_en,
	// result
	output logic      [11:0] addr
);
	import dmx_pkg::*;

	// operand address formation
	always_comb
	begin
		if (a)
			addr = {bank[3:0], f};
		else if (ext_en && f <= DMX_ILO_MAX)
			addr = ilo_base + {4'h0, f};
		else if (f <= DMX_ILO_MAX)
			addr = {DMX_ACC_LOBANK, f};
		else
			addr = {DMX_ACC_HIBANK, f};
	end

endmodule : dmx_addr

/* core/dmx_exec.sv */
// How it works
// - pointer load writes 12-bit literal, flags untouched
// - pointer select picks one of three
// - file move to accumulator or back
// - 8-bit operand reaches whole 256-byte bank
// - access bit 0 selects access bank
// - access bit 1 uses bank pointer
// - extended set, f<=5Fh uses indexed offset
// - memory move: C-word source, F-word destination
// - memory move reaches full 4096-byte space
// - accumulator may be source or destination
// - counter low, stack top never move targets
// - bank load writes only low nibble
// - accumulator literal load, one cycle, no flags
`timescale 1ns/1ns
module dmx_exec (
	// clock and reset
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	// write address channel
	input  wire logic [dmx_pkg::DMX_AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	// write data channel
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	// write response channel
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	// read address channel
	input  wire logic [dmx_pkg::DMX_AXI_AW-1:0] s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	// read data channel
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	// data memory port, read data one cycle after mem_rd
	output logic [11:0]                         mem_addr,
	output logic                                mem_rd,
	output logic                                mem_wr,
	output logic [7:0]                          mem_wdata,
	input  wire logic [7:0]                     mem_rdata
);
	import dmx_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DATA, ST_WR} dmx_state_e;
	typedef enum logic [1:0] {PEND_NONE, PEND_PTR, PEND_MM} dmx_pend_e;

	dmx_state_e  state;
	dmx_pend_e   pend;
	logic [1:0]  pend_sel;
	logic [11:0] src_q;
	logic [11:0] dst_q;
	logic        cur_fmove;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        ext_en;
	logic [7:0]  acc;
	logic [7:0]  bank;
	logic        neg_flag;
	logic        zero_flag;
	logic        illegal;
	logic        blocked;
	logic [11:0] ptr [3];
	logic [11:0] opnd_addr;
	logic        wr_fire;
	logic        instr_go;
	logic        ok1;
	logic        ptr_lo_go;
	logic        mm_go;
	logic        fm_go;
	logic        clash;
	logic        wr_ok;
	logic [7:0]  move_val;
	logic        dst_prot;
	logic [31:0] next_rdata;
	logic        rd_ok;

	dmx_dec_if dif ();

	dmx_decode u_decode (
		.dif (dif.dec)
	);

	dmx_addr u_addr (
		.f        (dif.f),
		.a        (dif.a),
		.bank     (bank),
		.ilo_base (ptr[2]),
		.ext_en   (ext_en),
		.addr     (opnd_addr)
	);

	// write commit and instruction dispatch
	assign dif.word  = w_data_q[15:0];
	assign wr_fire   = aw_held && w_held && !s_axi_bvalid;
	assign instr_go  = wr_fire && aw_addr_q == DMX_OFF_INSTR && (&w_strb_q[1:0])
		&& state == ST_IDLE;
	assign ok1       = instr_go && pend == PEND_NONE;
	assign ptr_lo_go = instr_go && dif.op == DMX_SECOND && pend == PEND_PTR;
	assign mm_go     = instr_go && dif.op == DMX_SECOND && pend == PEND_MM;
	assign fm_go     = ok1 && dif.op == DMX_FMOVE;
	assign clash     = instr_go && pend != PEND_NONE && dif.op != DMX_SECOND;
	assign move_val  = (src_q == DMX_ACC_ADDR) ? acc : mem_rdata;
	assign dst_prot  = dst_q[11:2] == DMX_PROT_BASE[11:2];

	// decode of a write target; busy instruction writes are refused
	always_comb
	begin
		wr_ok = 1'b1;
		unique case (aw_addr_q)
			DMX_OFF_CTRL, DMX_OFF_STATUS, DMX_OFF_ACC, DMX_OFF_BANK: wr_ok = 1'b1;
			DMX_OFF_INSTR: wr_ok = (&w_strb_q[1:0]) && state == ST_IDLE;
			default:       wr_ok = 1'b0;
		endcase
	end

	// write channel handshakes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= DMX_RESP_OKAY;
		end
		else
		begin
			if (!aw_held && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (!w_held && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held       <= 1'b1;
				aw_addr_q     <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held       <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? DMX_RESP_OKAY : DMX_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read mux; upper bits of narrow registers read as zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		rd_ok      = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			DMX_OFF_CTRL:   next_rdata[0] = ext_en;
			DMX_OFF_INSTR:  next_rdata[15:0] = w_data_q[15:0];
			DMX_OFF_STATUS: next_rdata[5:0] = {blocked, illegal, zero_flag, neg_flag,
				pend != PEND_NONE, state != ST_IDLE};
			DMX_OFF_ACC:    next_rdata[7:0] = acc;
			DMX_OFF_BANK:   next_rdata[7:0] = bank;
			DMX_OFF_PTR0:   next_rdata[11:0] = ptr[0];
			DMX_OFF_PTR1:   next_rdata[11:0] = ptr[1];
			DMX_OFF_PTR2:   next_rdata[11:0] = ptr[2];
			default:        rd_ok = 1'b0;
		endcase
	end

	// read channel, one beat answer the cycle after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= DMX_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= rd_ok ? DMX_RESP_OKAY : DMX_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	// control register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_en <= 1'b0;
		else if (wr_fire && aw_addr_q == DMX_OFF_CTRL && w_strb_q[0])
			ext_en <= w_data_q[0];
	end

	// accumulator: bus, literal load, move results
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			acc <= DMX_RST_BYTE;
		else if (ok1 && dif.op == DMX_ACCLIT)
			acc <= dif.f;
		else if (state == ST_DATA && dst_q == DMX_ACC_ADDR)
			acc <= move_val;
		else if (wr_fire && aw_addr_q == DMX_OFF_ACC && w_strb_q[0])
			acc <= w_data_q[7:0];
	end

	// bank pointer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bank <= DMX_RST_BYTE;
		// low nibble only, upper reads zero
		else if (ok1 && dif.op == DMX_BANK)
			bank <= {4'h0, dif.f[3:0]};
		else if (wr_fire && aw_addr_q == DMX_OFF_BANK && w_strb_q[0])
			bank <= {4'h0, w_data_q[3:0]};
	end

	// indirect pointers, one per entry
	for (genvar gi = 0; gi < 3; gi++)
	begin : g_ptr
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				ptr[gi] <= DMX_RST_PTR;
			else if (ok1 && dif.op == DMX_PTR1 && dif.psel == 2'(gi))
				ptr[gi][11:8] <= dif.lit12[3:0];
			else if (ptr_lo_go && pend_sel == 2'(gi))
				ptr[gi][7:0] <= dif.f;
		end
	end

	// status flags, file move only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			neg_flag  <= 1'b0;
			zero_flag <= 1'b0;
		end
		// negative and zero from moved value
		else if (state == ST_DATA && cur_fmove)
		begin
			neg_flag  <= move_val[7];
			zero_flag <= move_val == 8'h00;
		end
	end

	// sticky error bits, write one to clear, a new event wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			illegal <= 1'b0;
			blocked <= 1'b0;
		end
		else
		begin
			if (clash || (ok1 && dif.op == DMX_ILLEGAL))
				illegal <= 1'b1;
			else if (wr_fire && aw_addr_q == DMX_OFF_STATUS && w_strb_q[0]
				&& w_data_q[DMX_ST_ILLEGAL])
				illegal <= 1'b0;
			if (state == ST_DATA && dst_prot)
				blocked <= 1'b1;
			else if (wr_fire && aw_addr_q == DMX_OFF_STATUS && w_strb_q[0]
				&& w_data_q[DMX_ST_BLOCKED])
				blocked <= 1'b0;
		end
	end

	// two-word tracking; a stray word cancels the pending pair
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend     <= PEND_NONE;
			pend_sel <= 2'h0;
		end
		else if (instr_go)
		begin
			pend <= PEND_NONE;
			if (ok1 && dif.op == DMX_PTR1)
			begin
				pend     <= PEND_PTR;
				pend_sel <= dif.psel;
			end
			else if (ok1 && dif.op == DMX_MM1)
				pend <= PEND_MM;
		end
	end

	// memory sequencer: read, capture, optional write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state     <= ST_IDLE;
			src_q     <= 12'h000;
			dst_q     <= 12'h000;
			cur_fmove <= 1'b0;
			mem_addr  <= 12'h000;
			mem_rd    <= 1'b0;
			mem_wr    <= 1'b0;
			mem_wdata <= 8'h00;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					// full 12-bit source from first word
					if (ok1 && dif.op == DMX_MM1)
						src_q <= dif.lit12;
					if (fm_go)
					begin
						src_q     <= opnd_addr;
						dst_q     <= dif.d ? opnd_addr : DMX_ACC_ADDR;
						cur_fmove <= 1'b1;
						mem_addr  <= opnd_addr;
						mem_rd    <= 1'b1;
						state     <= ST_WAIT;
					end
					else if (mm_go)
					begin
						dst_q     <= dif.lit12;
						cur_fmove <= 1'b0;
						mem_addr  <= src_q;
						mem_rd    <= 1'b1;
						state     <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					mem_rd <= 1'b0;
					state  <= ST_DATA;
				end
				ST_DATA:
				begin
					if (dst_q != DMX_ACC_ADDR && !dst_prot)
					begin
						mem_addr  <= dst_q;
						mem_wdata <= move_val;
						mem_wr    <= 1'b1;
						state     <= ST_WR;
					end
					else
						state <= ST_IDLE;
				end
				ST_WR:
				begin
					mem_wr <= 1'b0;
					state  <= ST_IDLE;
				end
			endcase
		end
	end

	chk_acclit_load: assert property (@(posedge aclk) disable iff (!aresetn)
		ok1 && dif.op == DMX_ACCLIT |=> acc == $past(w_data_q[7:0]) && $stable(zero_flag))
		else $error("accumulator literal load wrong");
	chk_bank_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
		ok1 && dif.op == DMX_BANK |=> bank == {4'h0, $past(w_data_q[3:0])})
		else $error("bank pointer load wrong");
	chk_ptr_high: assert property (@(posedge aclk) disable iff (!aresetn)
		ok1 && dif.op == DMX_PTR1 && dif.psel == 2'h2
		|=> ptr[2][11:8] == $past(w_data_q[3:0]) && pend == PEND_PTR)
		else $error("pointer high nibble wrong");
	chk_ptr_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		ptr_lo_go |=> $stable(neg_flag) && $stable(zero_flag) && pend == PEND_NONE)
		else $error("pointer load touched flags");
	chk_fmove_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		state == ST_DATA && cur_fmove |=> zero_flag == ($past(move_val) == 8'h00))
		else $error("file move flags wrong");
	chk_mm_write: assert property (@(posedge aclk) disable iff (!aresetn)
		mm_go && w_data_q[11:0] != DMX_ACC_ADDR && w_data_q[11:2] != DMX_PROT_BASE[11:2]
		|-> ##3 mem_wr && mem_addr == $past(w_data_q[11:0], 3))
		else $error("memory move write late or misaddressed");
	chk_prot_dst: assert property (@(posedge aclk) disable iff (!aresetn)
		mem_wr |-> mem_addr[11:2] != DMX_PROT_BASE[11:2])
		else $error("write to protected register");
	chk_access_bank: assert property (@(posedge aclk) disable iff (!aresetn)
		fm_go && !dif.a && !ext_en
		|=> mem_rd && mem_addr[11:8] == (($past(dif.f) <= DMX_ILO_MAX) ? 4'h0 : 4'hF))
		else $error("access bank address wrong");
	chk_banked: assert property (@(posedge aclk) disable iff (!aresetn)
		fm_go && dif.a |=> mem_addr == {$past(bank[3:0]), $past(dif.f)})
		else $error("banked address wrong");

	cov_mm_to_acc: cover property (@(posedge aclk) disable iff (!aresetn)
		mm_go && w_data_q[11:0] == DMX_ACC_ADDR);
	cov_fmove_back: cover property (@(posedge aclk) disable iff (!aresetn)
		fm_go && dif.d ##3 mem_wr);
	cov_ptr_pair: cover property (@(posedge aclk) disable iff (!aresetn)
		ptr_lo_go);
	cov_ilo: cover property (@(posedge aclk) disable iff (!aresetn)
		fm_go && !dif.a && ext_en && dif.f <= DMX_ILO_MAX);

endmodule : dmx_exec

/* tb/data_move_instruction_exec_tb.sv */
`timescale 1ns/1ns
module data_move_instruction_exec_tb;
	import dmx_pkg::*;
	typedef struct packed {logic rd; logic [31:0] dat; logic [1:0] rsp;} dmx_note_s;
	// clock and reset
	logic        aclk;
	logic        aresetn;
	// register bus
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	// data memory
	logic [11:0] mem_addr;
	logic        mem_rd;
	logic        mem_wr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic [7:0]  mem [4096];
	// notes and counters
	dmx_note_s   exp_q [$];
	logic [19:0] mw_q [$];
	dmx_note_s   nt;
	int          error_cnt;
	int          cmp_count;
	// expected state
	logic [31:0] st;
	logic [7:0]  acc;
	logic [7:0]  v;
	logic [7:0]  f;
	logic        fa;
	logic        fe;
	logic [11:0] p [3];
	logic [11:0] ea;
	logic [11:0] src;

	// free running clock
	initial aclk = 1'b0;
	always #10 aclk = ~aclk;

	dmx_exec dut (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (wstrb),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.mem_addr      (mem_addr),
		.mem_rd        (mem_rd),
		.mem_wr        (mem_wr),
		.mem_wdata     (mem_wdata),
		.mem_rdata     (mem_rdata)
	);

	// registered memory; stale data inverted so a late sample cannot pass
	always @(posedge aclk)
	begin
		if (mem_rd === 1'b1)
			mem_rdata <= mem[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
		if (mem_wr === 1'b1)
			mem[mem_addr] <= mem_wdata;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// answers and memory writes meet the oldest note
	always @(posedge aclk)
	begin
		if ((bvalid && bready) || (rvalid && rready))
		begin
			if (exp_q.size() == 0)
				check("bus answer", 32'h1, 32'h0);
			else
			begin
				nt = exp_q.pop_front();
				check("resp", {30'h0, (rvalid && rready) ? rresp : bresp}, {30'h0, nt.rsp});
				if (nt.rd)
					check("rdata", rdata, nt.dat);
			end
		end
		if (mem_wr === 1'b1)
		begin
			if (mw_q.size() == 0)
				check("memory write", 32'h1, 32'h0);
			else
				check("memory write", {12'h0, mem_addr, mem_wdata}, {12'h0, mw_q.pop_front()});
		end
	end

	// aw and w offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		bit ad;
		bit wd;
		exp_q.push_back('{1'b0, 32'h0, r});
		ad = 0;
		wd = 0;
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (!ad && awready === 1'b1)
			begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1)
			begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back('{1'b1, d, r});
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask : rd

	// instruction word, then room for the sequencer to go idle
	task automatic ins(input logic [15:0] w);
		wr(DMX_OFF_INSTR, {16'h0000, w}, 4'hF, DMX_RESP_OKAY);
		repeat (8) @(posedge aclk);
	endtask : ins

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	// hang guard, far beyond the roughly 700 cycles the tests need
	initial
	begin
		#400000;
		error_cnt++;
		close_out();
	end

	initial
	begin
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		mem_rdata = 8'h00;
		foreach (mem[i]) mem[i] = 8'(i * 7);
		void'($urandom(26170));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, instruction word skipped
		for (int i = 0; i < 8; i++)
			if (i != 1) rd(8'(4 * i), 32'h0, DMX_RESP_OKAY);
		$display("test reset done");
		// literal to accumulator back to back, then a refused partial write
		st = 32'h0;
		for (int i = 0; i < 3; i++)
		begin
			acc = 8'($urandom);
			ins({8'h0E, acc});
			rd(DMX_OFF_ACC, {24'h0, acc}, DMX_RESP_OKAY);
		end
		wr(DMX_OFF_INSTR, {16'h0, 8'h0E, ~acc}, 4'h1, DMX_RESP_SLVERR);
		rd(DMX_OFF_ACC, {24'h0, acc}, DMX_RESP_OKAY);
		rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		$display("test accumulator load done");
		// bank load with upper literal bits set
		v = 8'($urandom) | 8'hF0;
		ins({8'h01, v});
		rd(DMX_OFF_BANK, {28'h0, v[3:0]}, DMX_RESP_OKAY);
		ins(16'h0105);
		rd(DMX_OFF_BANK, 32'h5, DMX_RESP_OKAY);
		$display("test bank load done");
		// pointer load, every pointer, high part lands first
		for (int s = 0; s < 3; s++)
		begin
			p[s] = 12'($urandom) & 12'h7FF;
			ins({8'hEE, 2'b00, 2'(s), p[s][11:8]});
			rd(DMX_OFF_PTR0 + 8'(4 * s), {20'h0, p[s][11:8], 8'h00}, DMX_RESP_OKAY);
			ins({8'hF0, p[s][7:0]});
			rd(DMX_OFF_PTR0 + 8'(4 * s), {20'h0, p[s]}, DMX_RESP_OKAY);
		end
		rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		ins(16'hEE30);
		st[DMX_ST_ILLEGAL] = 1'b1;
		rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		wr(DMX_OFF_STATUS, 32'h10, 4'hF, DMX_RESP_OKAY);
		// pair broken by a one-word instruction
		ins(16'hEE01);
		p[0][11:8] = 4'h1;
		ins(16'h0E55);
		rd(DMX_OFF_ACC, {24'h0, acc}, DMX_RESP_OKAY);
		rd(DMX_OFF_PTR0, {20'h0, p[0]}, DMX_RESP_OKAY);
		rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		wr(DMX_OFF_STATUS, 32'h10, 4'hF, DMX_RESP_OKAY);
		st[DMX_ST_ILLEGAL] = 1'b0;
		wr(DMX_OFF_PTR0, 32'h0, 4'hF, DMX_RESP_SLVERR);
		wr(8'h40, 32'h0, 4'hF, DMX_RESP_SLVERR);
		rd(8'h40, 32'h0, DMX_RESP_SLVERR);
		rd(DMX_OFF_PTR0, {20'h0, p[0]}, DMX_RESP_OKAY);
		$display("test pointer load done");
		// file move into the accumulator over every addressing case
		for (int i = 0; i < 5; i++)
		begin
			fa = (i == 0);
			fe = (i > 2);
			f = (i == 0) ? 8'($urandom) : ((i == 1) ? 8'h20 : ((i == 3) ? 8'h5F : 8'h60));
			v = (i == 1) ? 8'h00 : ((i == 2) ? 8'h80 : 8'($urandom));
			ea = fa ? {4'h5, f} : ((fe && f <= 8'h5F) ? p[2] + 12'(f) : {f > 8'h5F ? 4'hF : 4'h0, f});
			mem[ea] = v;
			wr(DMX_OFF_CTRL, {31'h0, fe}, 4'hF, DMX_RESP_OKAY);
			ins({6'b010100, 1'b0, fa, f});
			acc = v;
			st[DMX_ST_NEG] = v[7];
			st[DMX_ST_ZERO] = (v == 8'h00);
			rd(DMX_OFF_ACC, {24'h0, acc}, DMX_RESP_OKAY);
			rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		end
		// file move back to the register
		v = 8'($urandom);
		mem[12'h5C3] = v;
		mw_q.push_back({12'h5C3, v});
		ins({6'b010100, 1'b1, 1'b1, 8'hC3});
		st[DMX_ST_NEG] = v[7];
		st[DMX_ST_ZERO] = (v == 8'h00);
		rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		rd(DMX_OFF_ACC, {24'h0, acc}, DMX_RESP_OKAY);
		$display("test file move done");
		// memory to memory, plain, from and to the accumulator
		src = 12'($urandom) & 12'h7FF;
		mw_q.push_back({src | 12'h800, mem[src]});
		ins({DMX_OPC_MM1, src});
		ins({DMX_OPC_SECOND, src | 12'h800});
		mw_q.push_back({12'h100, acc});
		ins({DMX_OPC_MM1, DMX_ACC_ADDR});
		ins(16'hF100);
		acc = mem[12'h200];
		ins(16'hC200);
		ins({DMX_OPC_SECOND, DMX_ACC_ADDR});
		rd(DMX_OFF_ACC, {24'h0, acc}, DMX_RESP_OKAY);
		// far ends of the data space
		mw_q.push_back({12'h000, mem[12'hFFF]});
		ins(16'hCFFF);
		ins(16'hF000);
		// protected destinations drop their writes
		for (int i = 0; i < 4; i++)
		begin
			ins(16'hC300);
			ins({DMX_OPC_SECOND, DMX_PROT_BASE + 12'(i)});
		end
		st[DMX_ST_BLOCKED] = 1'b1;
		rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		ins(16'hF123);
		rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		rd(DMX_OFF_ACC, {24'h0, acc}, DMX_RESP_OKAY);
		// software side: blocked clears on a one, bank keeps only its low nibble
		wr(DMX_OFF_STATUS, 32'h20, 4'hF, DMX_RESP_OKAY);
		st[DMX_ST_BLOCKED] = 1'b0;
		rd(DMX_OFF_STATUS, st, DMX_RESP_OKAY);
		wr(DMX_OFF_BANK, 32'hFFFF_FFA9, 4'hF, DMX_RESP_OKAY);
		rd(DMX_OFF_BANK, 32'h9, DMX_RESP_OKAY);
		acc = 8'($urandom);
		wr(DMX_OFF_ACC, {24'h0, acc}, 4'hF, DMX_RESP_OKAY);
		rd(DMX_OFF_ACC, {24'h0, acc}, DMX_RESP_OKAY);
		repeat (4) @(posedge aclk);
		check("memory notes left", 32'(mw_q.size()), 32'h0);
		check("bus notes left", 32'(exp_q.size()), 32'h0);
		$display("test memory move done");
		close_out();
	end
endmodule : data_move_instruction_exec_tb
